// ---- esqm_cnt_sink.sv ----
// Counter memory model fed by the block's update pulses
`default_nettype none
module esqm_cnt_sink (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic portCntVld,
  input wire logic svcCntVld,
  input wire logic abortCntVld,
  input wire logic [esqm_pkg::LEN_W-1:0] cntOctets,
  output logic [esqm_pkg::FRM_CNT_W-1:0] portFrames,
  output logic [esqm_pkg::OCT_CNT_W-1:0] portOctets,
  output logic [esqm_pkg::FRM_CNT_W-1:0] svcFrames,
  output logic [esqm_pkg::FRM_CNT_W-1:0] abortFrames
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      portFrames <= '0;
      portOctets <= '0;
      svcFrames <= '0;
      abortFrames <= '0;
    end else begin
      // Octets added as 40 bits; the total wraps only after 2^40 octets
      if (portCntVld) begin
        portFrames <= portFrames + 1'b1;
        portOctets <= portOctets + 40'(cntOctets);
      end
      if (svcCntVld) svcFrames <= svcFrames + 1'b1;
      if (abortCntVld) abortFrames <= abortFrames + 1'b1;
    end
  end
endmodule // esqm_cnt_sink
`default_nettype wire

// ---- esqm_core.sv ----
// Egress statistics index selection, update gating and QoS mapping
//
// Overview of operation
// - Port index is port plus priority
// - Mode 0 service index: base plus offset
// - Mode 0 fallback to 4096 ingress indexes
// - Modes 0,1 colour from drop map
// - Mode 1 skips frames without service index
// - Mode 2 uses ingress service index
// - Mode 3 uses pushed, classified or router VID
// - Modes 2,3 colour is DMAC bit 40
// - Port counts transmitted, non-extracted frames
// - Port counts cover every port number
// - Service counts need physical, mode, transmit
// - Extracted frames counted at/after point
// - Injected frames counted at/before point
// - Abort counts, rewriter ones when enabled
// - Protection flag picks alternate base
// - Two 4096-entry map resources, four fields
// - Four map lookups per frame
// - Map address: base high, key low
// - Missing key property gives invalid result
// - Table 1, else 0, else fixed value
// - Table 3, else 2, else fixed value
// - Tables 0,1 in A; 2,3 in B
// - Octets and frames counted side by side
// - Port and service index widths
// - Stacking disable blocks service counting on stack-header ports
//
// The address map and the AXI4-Lite register port were left to the implementer.
`default_nettype none
module esqm_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frmValid,
  input wire logic [esqm_pkg::PORT_W-1:0] frmPort,
  input wire logic [esqm_pkg::PRIO_W-1:0] frmPrio,
  input wire esqm_pkg::esqm_action_t frmAction,
  input wire logic [esqm_pkg::PT_W-1:0] frmPoint,
  input wire logic frmAbort,
  input wire logic frmAbortQueue,
  input wire logic [esqm_pkg::LEN_W-1:0] frmLen,
  input wire logic [esqm_pkg::COS_W-1:0] frmCosId,
  input wire logic [esqm_pkg::DP_W-1:0] frmDp,
  input wire logic [esqm_pkg::ISDX_W-1:0] frmIsdx,
  input wire logic [esqm_pkg::VID_W-1:0] frmVid,
  input wire logic frmPushed,
  input wire logic [esqm_pkg::VID_W-1:0] frmPushVid,
  input wire logic frmRouted,
  input wire logic [esqm_pkg::VID_W-1:0] frmRouterVid,
  input wire logic frmDmacGroup,
  input wire logic frmProtActive,
  input wire logic lookupEna,
  input wire logic protSel,
  input wire logic [esqm_pkg::SVC_W-1:0] svcBase,
  input wire logic [esqm_pkg::SVC_W-1:0] svcBaseProt,
  input wire logic [8*esqm_pkg::COS_OFS_W-1:0] cosOffsets,
  input wire logic [4*esqm_pkg::KEY_W-1:0] mapKeySel,
  input wire logic [4*esqm_pkg::BASE_W-1:0] mapBase,
  input wire logic [esqm_pkg::KEY_NUM*esqm_pkg::KVAL_W-1:0] keyVals,
  input wire logic [esqm_pkg::KEY_NUM-1:0] keyValid,
  input wire logic [esqm_pkg::MAP_W-1:0] fixedMap,
  output logic portCntVld,
  output logic [esqm_pkg::PORT_W+esqm_pkg::PRIO_W-1:0] portCntIdx,
  output logic portCntColor,
  output logic svcCntVld,
  output logic [esqm_pkg::SVC_W-1:0] svcCntIdx,
  output logic svcCntColor,
  output logic abortCntVld,
  output logic [esqm_pkg::PORT_W-1:0] abortCntPort,
  output logic [esqm_pkg::LEN_W-1:0] cntOctets,
  output logic mapResVld,
  output logic [esqm_pkg::MAP_W-1:0] mapResLo,
  output logic [esqm_pkg::MAP_W-1:0] mapResHi
);
  localparam int KP = esqm_pkg::KEY_NUM + 1;
  localparam int MA = esqm_pkg::MAP_AW;

  logic [31:0] ctrlReg;
  logic [esqm_pkg::PORT_W-1:0] portSel;
  logic [MA:0] mapAddr;
  logic [esqm_pkg::SVC_W:0] lastSvc;
  logic [esqm_pkg::CFG_W-1:0] portCfg [esqm_pkg::NUM_PORTS];
  logic [esqm_pkg::MAP_W-1:0] mapMem [2*esqm_pkg::MAP_DEPTH];

  // Bus decode
  wire [31:0] strbMask;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_strb
      assign strbMask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end
  endgenerate
  wire wrTake = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire rdTake = s_axi_arready && s_axi_arvalid;
  wire [4:0] wa = s_axi_awaddr;
  wire [4:0] ra = s_axi_araddr;
  wire wrCtrl = wrTake && wa == esqm_pkg::REG_CTRL;
  wire wrSel = wrTake && wa == esqm_pkg::REG_PORT_SEL;
  wire wrCfg = wrTake && wa == esqm_pkg::REG_PORT_CFG;
  wire wrMapA = wrTake && wa == esqm_pkg::REG_MAP_ADDR;
  wire wrMapD = wrTake && wa == esqm_pkg::REG_MAP_DATA;
  wire wrHit = wrCtrl || wrSel || wrCfg || wrMapA || wrMapD;
  wire [31:0] ctrlNew = (ctrlReg & ~strbMask) | (s_axi_wdata & strbMask);
  wire [esqm_pkg::CFG_W-1:0] cfgOld = portCfg[portSel];
  wire [esqm_pkg::CFG_W-1:0] cfgNew = (cfgOld
    & ~strbMask[esqm_pkg::CFG_W-1:0])
    | (s_axi_wdata[esqm_pkg::CFG_W-1:0] & strbMask[esqm_pkg::CFG_W-1:0]);
  wire [esqm_pkg::MAP_W-1:0] mapOld = mapMem[mapAddr];
  wire [esqm_pkg::MAP_W-1:0] mapNew = (mapOld
    & ~strbMask[esqm_pkg::MAP_W-1:0])
    | (s_axi_wdata[esqm_pkg::MAP_W-1:0] & strbMask[esqm_pkg::MAP_W-1:0]);
  wire [31:0] mapAddrWord = 32'(mapAddr[MA-1:0])
    | (32'(mapAddr[MA]) << esqm_pkg::MAP_RES_BIT);
  wire rdHit = ra == esqm_pkg::REG_CTRL || ra == esqm_pkg::REG_PORT_SEL
    || ra == esqm_pkg::REG_PORT_CFG || ra == esqm_pkg::REG_MAP_ADDR
    || ra == esqm_pkg::REG_MAP_DATA || ra == esqm_pkg::REG_LAST_SVC;
  wire [31:0] rdMux =
    ra == esqm_pkg::REG_CTRL ? ctrlReg :
    ra == esqm_pkg::REG_PORT_SEL ? 32'(portSel) :
    ra == esqm_pkg::REG_PORT_CFG ? 32'(cfgOld) :
    ra == esqm_pkg::REG_MAP_ADDR ? mapAddrWord :
    ra == esqm_pkg::REG_MAP_DATA ? 32'(mapOld) :
    ra == esqm_pkg::REG_LAST_SVC ? 32'(lastSvc) : 32'h0;

  // Ready is a one-cycle pulse; the master holds valid until then
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= esqm_pkg::RESP_OK;
    end else if (ce) begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid
        && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready <= !s_axi_awready && !s_axi_bvalid
        && s_axi_awvalid && s_axi_wvalid;
      if (wrTake) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? esqm_pkg::RESP_OK : esqm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= esqm_pkg::RESP_OK;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rdTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? esqm_pkg::RESP_OK : esqm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrlReg <= esqm_pkg::CTRL_RST;
      portSel <= '0;
      mapAddr <= '0;
      for (int i = 0; i < esqm_pkg::NUM_PORTS; i++) begin
        portCfg[i] <= 9'(esqm_pkg::EXT_PT_RST)
          | (9'(esqm_pkg::INJECT_PT_RST) << esqm_pkg::CFG_INJECT_LSB);
      end
    end else if (ce) begin
      if (wrCtrl) ctrlReg <= ctrlNew;
      if (wrSel) portSel <= s_axi_wdata[esqm_pkg::PORT_W-1:0];
      if (wrCfg) portCfg[portSel] <= cfgNew;
      if (wrMapA) begin
        mapAddr <= {s_axi_wdata[esqm_pkg::MAP_RES_BIT], s_axi_wdata[MA-1:0]};
      end
    end
  end

  // map storage: A low half, B high half; no reset on table data
  always_ff @(posedge ref_clk) begin
    if (rst_n && ce && wrMapD) mapMem[mapAddr] <= mapNew;
  end

  // Frame decode
  wire [1:0] statMode = ctrlReg[esqm_pkg::CTRL_MODE_LSB +: 2];
  wire abortEna = ctrlReg[esqm_pkg::CTRL_ABORT_EN];
  wire [3:0] dpMap = ctrlReg[esqm_pkg::CTRL_DPMAP_LSB +: 4];
  wire [esqm_pkg::CFG_W-1:0] frmCfg = portCfg[frmPort];
  wire [esqm_pkg::PT_W-1:0] cfgExtPt = frmCfg[esqm_pkg::CFG_EXT_LSB +: 3];
  wire [esqm_pkg::PT_W-1:0] cfgInjPt = frmCfg[esqm_pkg::CFG_INJECT_LSB +: 3];
  wire stackBlock = ctrlReg[esqm_pkg::CTRL_STACK_DIS]
    && frmCfg[esqm_pkg::CFG_STACK_HDR];
  wire [esqm_pkg::SVC_W-1:0] baseSel =
    (protSel && frmProtActive) ? svcBaseProt : svcBase;
  wire svcAvail = lookupEna && baseSel != '0;
  wire [esqm_pkg::COS_OFS_W-1:0] cosOfs =
    cosOffsets[frmCosId*esqm_pkg::COS_OFS_W +: esqm_pkg::COS_OFS_W];
  wire [esqm_pkg::SVC_W-1:0] svcIdxLkp = baseSel + 13'(cosOfs);
  wire [esqm_pkg::SVC_W-1:0] isdxIdx = 13'(frmIsdx);
  wire [esqm_pkg::VID_W-1:0] vidSel = frmRouted ? frmRouterVid :
    frmPushed ? frmPushVid : frmVid;
  wire [esqm_pkg::SVC_W-1:0] svcIdxSel =
    statMode == esqm_pkg::MODE_VID ? 13'(vidSel) :
    statMode == esqm_pkg::MODE_ISDX ? isdxIdx :
    svcAvail ? svcIdxLkp : isdxIdx;
  wire modeOk = statMode != esqm_pkg::MODE_SVC_ONLY || svcAvail;
  wire colorSel = statMode[1] ? frmDmacGroup : dpMap[frmDp];
  wire isExt = frmAction == esqm_pkg::ACT_EXTRACT
    || frmAction == esqm_pkg::ACT_EXTRACT_MEP
    || frmAction == esqm_pkg::ACT_LOOP_ASM;
  wire isInj = frmAction == esqm_pkg::ACT_INJECT
    || frmAction == esqm_pkg::ACT_LOOP_QUEUE;
  wire extOk = !isExt || frmPoint >= cfgExtPt;
  wire injOk = !isInj || frmPoint <= cfgInjPt;
  // port update gate, any port number
  wire portUpd = frmValid && !frmAbort && !isExt;
  wire svcUpd = frmValid && frmPort < esqm_pkg::NUM_PHYS && modeOk
    && !stackBlock && extOk && injOk && !frmAbort
    && frmAction != esqm_pkg::ACT_LATE_EXTRACT;
  wire abortUpd = frmValid && frmAbort && (frmAbortQueue || abortEna);

  wire [KP*esqm_pkg::KVAL_W-1:0] keyPad = {6'h0, keyVals};
  wire [KP-1:0] keyVldPad = {1'b0, keyValid};
  wire [3:0] tblVld;
  wire [esqm_pkg::MAP_W-1:0] tblEnt [4];
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_tbl
      wire [esqm_pkg::KEY_W-1:0] key = mapKeySel[t*4 +: 4];
      wire [esqm_pkg::KVAL_W-1:0] kv = keyPad[key*6 +: 6];
      wire [MA-1:0] addr = 12'({mapBase[t*9 +: 9], 3'h0} + 12'(kv));
      assign tblVld[t] = keyVldPad[key];
      assign tblEnt[t] = mapMem[{t >= 2, addr}];
    end
  endgenerate
  wire [esqm_pkg::MAP_W-1:0] next_mapResLo = tblVld[1] ? tblEnt[1] :
    tblVld[0] ? tblEnt[0] : fixedMap;
  wire [esqm_pkg::MAP_W-1:0] next_mapResHi = tblVld[3] ? tblEnt[3] :
    tblVld[2] ? tblEnt[2] : fixedMap;

  // one registered update per class per frame
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      portCntVld <= 1'b0;
      svcCntVld <= 1'b0;
      abortCntVld <= 1'b0;
      mapResVld <= 1'b0;
    end else if (ce) begin
      portCntVld <= portUpd;
      svcCntVld <= svcUpd;
      abortCntVld <= abortUpd;
      mapResVld <= frmValid;
    end
  end

  // Payload holds its value between frames to keep toggling low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      portCntIdx <= '0;
      portCntColor <= 1'b0;
      svcCntIdx <= '0;
      svcCntColor <= 1'b0;
      abortCntPort <= '0;
      cntOctets <= '0;
      mapResLo <= '0;
      mapResHi <= '0;
      lastSvc <= '0;
    end else if (ce && frmValid) begin
      portCntIdx <= {frmPort, frmPrio};
      portCntColor <= colorSel;
      svcCntIdx <= svcIdxSel;
      svcCntColor <= colorSel;
      abortCntPort <= frmPort;
      // length feeds octet and frame counters together
      cntOctets <= frmLen;
      mapResLo <= next_mapResLo;
      mapResHi <= next_mapResHi;
      if (svcUpd) lastSvc <= {colorSel, svcIdxSel};
    end
  end

  sequence frmSeen;
    ce && frmValid;
  endsequence
  property updNext(c, o);
    @(posedge ref_clk) disable iff (!rst_n) frmSeen ##0 c |=> o;
  endproperty
  portGate_a: assert property (updNext(!frmAbort && !isExt, portCntVld))
    else $error("port counter not updated");
  extBlock_a: assert property (updNext(isExt, !portCntVld))
    else $error("extracted frame hit port counter");
  modeOne_a: assert property (updNext(
    statMode == esqm_pkg::MODE_SVC_ONLY && !svcAvail, !svcCntVld))
    else $error("mode 1 counted without service index");
  lateExt_a: assert property (updNext(
    frmAction == esqm_pkg::ACT_LATE_EXTRACT, !svcCntVld))
    else $error("late extraction counted");
  abortGate_a: assert property (updNext(
    frmAbort && !frmAbortQueue && !abortEna, !abortCntVld))
    else $error("rewriter abort counted while disabled");
  stackOff_a: assert property (updNext(stackBlock, !svcCntVld))
    else $error("service counted on stacking port");
  mcColor_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frmSeen ##0 statMode[1] |=> svcCntColor == $past(frmDmacGroup))
    else $error("colour not from DMAC bit");
  isdxFall_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frmSeen ##0 (statMode == esqm_pkg::MODE_SVC_ISDX && !svcAvail)
    |=> svcCntIdx == 13'($past(frmIsdx)))
    else $error("mode 0 fallback index wrong");
  mapFixed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frmSeen ##0 tblVld[1:0] == 2'h0 |=> mapResLo == $past(fixedMap))
    else $error("fixed value not used");
  bHold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule // esqm_core
`default_nettype wire

// ---- esqm_pkg.sv ----
// Constants and types for the egress statistics index and QoS map block
`default_nettype none
package esqm_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PORT_SEL = 5'h04;
  localparam logic [4:0] REG_PORT_CFG = 5'h08;
  localparam logic [4:0] REG_MAP_ADDR = 5'h0C;
  localparam logic [4:0] REG_MAP_DATA = 5'h10;
  localparam logic [4:0] REG_LAST_SVC = 5'h14;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ABORT_EN = 2;
  localparam int CTRL_STACK_DIS = 3;
  localparam int CTRL_DPMAP_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0;
  // Per-port configuration fields
  localparam int PT_W = 3;
  localparam int CFG_EXT_LSB = 0;
  localparam int CFG_INJECT_LSB = 4;
  localparam int CFG_STACK_HDR = 8;
  localparam int CFG_W = 9;
  localparam logic [PT_W-1:0] EXT_PT_RST = 3'h3;
  localparam logic [PT_W-1:0] INJECT_PT_RST = 3'h4;
  // Map entry: TC, DSCP, DEI, PCP
  localparam int MAP_W = 13;
  localparam int MAP_AW = 12;
  localparam int MAP_DEPTH = 4096;
  localparam int MAP_RES_BIT = 16;
  // Frame fields
  localparam int PORT_W = 7;
  localparam int NUM_PORTS = 128;
  localparam logic [PORT_W-1:0] NUM_PHYS = 7'h41;
  localparam int PRIO_W = 3;
  localparam int SVC_W = 13;
  localparam int ISDX_W = 12;
  localparam int VID_W = 12;
  localparam int COS_W = 3;
  localparam int COS_OFS_W = 3;
  localparam int DP_W = 2;
  localparam int KEY_W = 4;
  localparam int KEY_NUM = 15;
  localparam int KVAL_W = 6;
  localparam int BASE_W = 9;
  localparam int BASE_SHIFT = 3;
  localparam int LEN_W = 14;
  localparam int OCT_CNT_W = 40;
  localparam int FRM_CNT_W = 32;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] MODE_SVC_ISDX = 2'h0;
  localparam logic [1:0] MODE_SVC_ONLY = 2'h1;
  localparam logic [1:0] MODE_ISDX = 2'h2;
  localparam logic [1:0] MODE_VID = 2'h3;
  typedef enum logic [2:0] {
    ACT_FWD = 3'h0,
    ACT_EXTRACT = 3'h1,
    ACT_EXTRACT_MEP = 3'h2,
    ACT_LOOP_ASM = 3'h3,
    ACT_INJECT = 3'h4,
    ACT_LOOP_QUEUE = 3'h5,
    ACT_LATE_EXTRACT = 3'h6
  } esqm_action_t;
endpackage
`default_nettype wire

// ---- test_egress_stats_index_and_qos_map.sv ----
// Self-checking bench for the egress statistics and QoS map block
`default_nettype none
module test_egress_stats_index_and_qos_map;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic f, pv, pcol, sv, scol, av;
    logic [9:0] pidx;
    logic [12:0] sidx, lo, hi;
    logic [6:0] aport;
    logic [13:0] oct;
  } esqm_exp_t;
  logic ref_clk, rst_n, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, frmDp, mode, resp;
  logic frmValid, frmAbort, frmAbortQueue, frmPushed, frmRouted;
  logic frmDmacGroup, frmProtActive, lookupEna, protSel;
  logic [6:0] frmPort, abortCntPort;
  logic [2:0] frmPrio, frmPoint, frmCosId;
  esqm_pkg::esqm_action_t frmAction;
  logic [13:0] frmLen, cntOctets, lastExp;
  logic [11:0] frmIsdx, frmVid, frmPushVid, frmRouterVid;
  logic [12:0] svcBase, svcBaseProt, fixedMap, svcCntIdx, mapResLo, mapResHi;
  logic [23:0] cosOffsets;
  logic [15:0] mapKeySel;
  logic [35:0] mapBase;
  logic [89:0] keyVals;
  logic [14:0] keyValid;
  logic portCntVld, portCntColor, svcCntVld, svcCntColor, abortCntVld;
  logic mapResVld, abortEn, stackDis, run;
  logic [9:0] portCntIdx;
  logic [31:0] portFrames, svcFrames, abortFrames, r, d;
  logic [39:0] portOctets, expPortOct;
  logic [3:0] dpMap;
  logic [2:0] cfgExt [128];
  logic [2:0] cfgInj [128];
  logic cfgHdr [128];
  logic [12:0] mapA [64];
  logic [12:0] mapB [64];
  esqm_exp_t expQ [$];
  esqm_exp_t e;
  integer n_mismatch, check_count, seed, i, k, expPortFrm, expSvcFrm;
  integer expAbortFrm;
  wire [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};

  esqm_core uut (.ref_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .frmValid, .frmPort, .frmPrio, .frmAction, .frmPoint, .frmAbort,
    .frmAbortQueue, .frmLen, .frmCosId, .frmDp, .frmIsdx, .frmVid, .frmPushed,
    .frmPushVid, .frmRouted, .frmRouterVid, .frmDmacGroup, .frmProtActive,
    .lookupEna, .protSel, .svcBase, .svcBaseProt, .cosOffsets, .mapKeySel,
    .mapBase, .keyVals, .keyValid, .fixedMap, .portCntVld, .portCntIdx,
    .portCntColor, .svcCntVld, .svcCntIdx, .svcCntColor, .abortCntVld,
    .abortCntPort, .cntOctets, .mapResVld, .mapResLo, .mapResHi);
  esqm_cnt_sink sink (.ref_clk, .rst_n, .portCntVld, .svcCntVld,
    .abortCntVld, .cntOctets, .portFrames, .portOctets, .svcFrames,
    .abortFrames);

  always #5 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] ex, got);
    check_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Bounded wait for a slave answer, sampled where it is settled
  task automatic wait_hi(input int w);
    integer n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (hs[w] !== 1'b1 && n < 100);
    if (hs[w] !== 1'b1) begin
      n_mismatch++;
      $display("ERROR handshake expected 1 seen %b", hs[w]);
      tally_and_finish();
    end
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] v,
                        input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    wait_hi(0);
    chk("wready", 1'b1, s_axi_wready);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_hi(1);
    chk("bresp", er, s_axi_bresp);
    @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] v,
                        output logic [1:0] rr);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(2);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    wait_hi(3);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rand_frame();
    logic [31:0] x, y, z, w, u, t;
    logic [89:0] kv;
    x = $random(seed);
    y = $random(seed);
    z = $random(seed);
    w = $random(seed);
    u = $random(seed);
    t = $random(seed);
    // Key values stay small so valid lookups hit written entries only
    for (int q = 0; q < 15; q++) kv[q*6+:6] = {3'h0, w[q*2+:3]};
    frmValid <= x[0] | x[1];
    frmPort <= x[2] ? 7'h05 : x[9:3];
    frmPrio <= x[12:10];
    frmAction <= esqm_pkg::esqm_action_t'(x[15:13] % 3'h7);
    frmPoint <= x[18:16];
    frmAbort <= x[19] & x[20];
    frmAbortQueue <= x[21];
    frmCosId <= x[24:22];
    frmDp <= x[26:25];
    frmPushed <= x[27];
    frmRouted <= x[28] & x[29];
    frmDmacGroup <= x[30];
    frmProtActive <= x[31];
    frmIsdx <= y[11:0];
    frmVid <= y[23:12];
    lookupEna <= y[24] | y[25];
    protSel <= y[26];
    frmLen <= {y[31:27], z[8:0]};
    frmPushVid <= z[20:9];
    frmRouterVid <= {z[31:21], y[0]};
    svcBase <= u[0] ? 13'h0000 : u[13:1];
    svcBaseProt <= u[26:14];
    cosOffsets <= {t[7:0], z[15:0]};
    fixedMap <= {u[31:27], t[7:0]};
    keyValid <= t[14:0];
    mapKeySel <= t[31:16];
    mapBase <= {w[31] ? 9'h005 : 9'h000, w[30] ? 9'h005 : 9'h000,
                w[29] ? 9'h005 : 9'h000, w[28] ? 9'h005 : 9'h000};
    keyVals <= kv;
  endtask

  task automatic model(output esqm_exp_t m);
    logic [12:0] base;
    logic [11:0] a [4];
    logic v [4];
    logic avail, extract_action, inject_action, col;
    logic [3:0] s;
    base = (protSel && frmProtActive) ? svcBaseProt : svcBase;
    avail = lookupEna && base != 13'h0000;
    extract_action = frmAction inside {esqm_pkg::ACT_EXTRACT, esqm_pkg::ACT_EXTRACT_MEP,
                            esqm_pkg::ACT_LOOP_ASM};
    inject_action = frmAction inside {esqm_pkg::ACT_INJECT, esqm_pkg::ACT_LOOP_QUEUE};
    col = mode < 2'h2 ? dpMap[frmDp] : frmDmacGroup;
    m.f = frmValid;
    m.pv = frmValid && !frmAbort && !extract_action;
    m.pidx = {frmPort, frmPrio};
    m.pcol = col;
    m.scol = col;
    m.sv = frmValid && !frmAbort && frmPort < esqm_pkg::NUM_PHYS &&
      frmAction != esqm_pkg::ACT_LATE_EXTRACT &&
      !(mode == esqm_pkg::MODE_SVC_ONLY && !avail) &&
      !(stackDis && cfgHdr[frmPort]) &&
      (!extract_action || frmPoint >= cfgExt[frmPort]) &&
      (!inject_action || frmPoint <= cfgInj[frmPort]);
    case (mode)
      esqm_pkg::MODE_ISDX: m.sidx = {1'b0, frmIsdx};
      esqm_pkg::MODE_VID:
        m.sidx = {1'b0, frmRouted ? frmRouterVid :
                  frmPushed ? frmPushVid : frmVid};
      default: m.sidx = avail ? base + {10'h000, cosOffsets[frmCosId*3+:3]}
                              : {1'b0, frmIsdx};
    endcase
    m.av = frmValid && frmAbort && (frmAbortQueue || abortEn);
    m.aport = frmPort;
    m.oct = frmLen;
    for (int q = 0; q < 4; q++) begin
      s = mapKeySel[q*4+:4];
      v[q] = s != 4'hF && keyValid[s];
      a[q] = {mapBase[q*9+:9], 3'h0} + {6'h00, keyVals[s*6+:6]};
    end
    m.lo = v[1] ? mapA[a[1]] : v[0] ? mapA[a[0]] : fixedMap;
    m.hi = v[3] ? mapB[a[3]] : v[2] ? mapB[a[2]] : fixedMap;
  endtask

  always @(negedge ref_clk) begin
    if (run) begin
      if (expQ.size() > 0) begin
        e = expQ.pop_front();
        chk("portCntVld", e.pv, portCntVld);
        chk("svcCntVld", e.sv, svcCntVld);
        chk("abortCntVld", e.av, abortCntVld);
        chk("mapResVld", e.f, mapResVld);
        if (e.pv) chk("portIdx", {e.pcol, e.pidx},
          {portCntColor, portCntIdx});
        if (e.sv) chk("svcIdx", {e.scol, e.sidx},
          {svcCntColor, svcCntIdx});
        if (e.av) chk("abortCntPort", e.aport, abortCntPort);
        if (e.f) chk("cntOctets", e.oct, cntOctets);
        if (e.f) chk("mapRes", {e.hi, e.lo},
          {mapResHi, mapResLo});
        if (e.sv) lastExp = {e.scol, e.sidx};
        expPortFrm += e.pv;
        expSvcFrm += e.sv;
        expAbortFrm += e.av;
        if (e.pv) expPortOct += 40'(e.oct);
      end
      model(e);
      expQ.push_back(e);
    end
  end

  initial begin
    {ref_clk, rst_n, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {frmValid, frmPort, frmPrio, frmPoint, frmAbort, frmAbortQueue, frmLen,
     frmCosId, frmDp, frmIsdx, frmVid, frmPushed, frmPushVid, frmRouted,
     frmRouterVid, frmDmacGroup, frmProtActive, lookupEna, protSel, svcBase,
     svcBaseProt, cosOffsets, mapKeySel, mapBase, keyVals, keyValid,
     fixedMap} = '0;
    frmAction = esqm_pkg::ACT_FWD;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    {n_mismatch, check_count, expPortFrm, expSvcFrm, expAbortFrm} = '0;
    expPortOct = '0;
    seed = 32'h8C7B5783;
    for (k = 0; k < 128; k++) begin
      cfgExt[k] = esqm_pkg::EXT_PT_RST;
      cfgInj[k] = esqm_pkg::INJECT_PT_RST;
      cfgHdr[k] = 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    axi_rd(esqm_pkg::REG_CTRL, d, resp);
    chk("ctrlReset", esqm_pkg::CTRL_RST, d);
    axi_rd(esqm_pkg::REG_PORT_CFG, d, resp);
    chk("portCfgReset", 32'h0000_0043, d);
    axi_rd(5'h18, d, resp);
    chk("rresp", esqm_pkg::RESP_SLVERR, resp);
    chk("rdataUnmapped", 32'h0, d);
    axi_wr(5'h1C, 32'hFFFF_FFFF, esqm_pkg::RESP_SLVERR);
    $display("test registers done");
    // Entries 0..7 and 40..47 of both resources cover bases 0 and 5
    for (k = 0; k < 32; k++) begin
      i = (k % 16 < 8) ? k % 8 : 32 + k % 16;
      r = $random(seed);
      axi_wr(esqm_pkg::REG_MAP_ADDR, ((k / 16) << esqm_pkg::MAP_RES_BIT) | i,
             esqm_pkg::RESP_OK);
      axi_wr(esqm_pkg::REG_MAP_DATA, {19'h0, r[12:0]}, esqm_pkg::RESP_OK);
      if (k < 16) mapA[i] = r[12:0];
      else mapB[i] = r[12:0];
    end
    axi_rd(esqm_pkg::REG_MAP_DATA, d, resp);
    chk("mapData", {19'h0, mapB[47]}, d);
    axi_wr(esqm_pkg::REG_PORT_SEL, 32'h5, esqm_pkg::RESP_OK);
    axi_wr(esqm_pkg::REG_PORT_CFG, 32'h125, esqm_pkg::RESP_OK);
    cfgExt[5] = 3'h5;
    cfgInj[5] = 3'h2;
    cfgHdr[5] = 1'b1;
    axi_rd(esqm_pkg::REG_PORT_CFG, d, resp);
    chk("portCfg", 32'h125, d);
    $display("test map and port config done");
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      mode = i[1:0];
      abortEn = i[2];
      stackDis = i[0] ^ i[2];
      dpMap = r[3:0];
      axi_wr(esqm_pkg::REG_CTRL, {20'h0, dpMap, 4'h0, stackDis, abortEn, mode},
             esqm_pkg::RESP_OK);
      run = 1'b1;
      repeat (150) begin
        @(posedge ref_clk);
        rand_frame();
      end
      @(posedge ref_clk);
      frmValid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      run = 1'b0;
      expQ.delete();
      $display("test mode %0d done", i);
    end
    ce <= 1'b0;
    frmValid <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("ceHold", 1'b0, mapResVld);
    @(posedge ref_clk);
    {ce, frmValid} <= 2'h2;
    chk("portFrames", expPortFrm, portFrames);
    chk("portOctets", expPortOct, portOctets);
    chk("svcFrames", expSvcFrm, svcFrames);
    chk("abortFrames", expAbortFrm, abortFrames);
    axi_rd(esqm_pkg::REG_LAST_SVC, d, resp);
    chk("lastSvc", 32'(lastExp), d);
    $display("test counter totals done");
    tally_and_finish();
  end
endmodule // test_egress_stats_index_and_qos_map
`default_nettype wire
